// ---- rtl/bfcc_core.sv ----
// start-up sequencing, overcurrent hiccup, block select and sync hand-over
// assumes analog comparators deliver trips and soft-start done as async levels,
// and the modulator ends each high-side pulse with pwm_end_i on this clock
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - high-side current checked against trip level once per switching cycle.
// - overcurrent turns high-side off at once until next cycle start.
// - first overcurrent loads the fault counter with one.
// - overcurrent in the very next cycle increments the counter.
// - a cycle without overcurrent clears the counter.
// - fourth consecutive detection shuts down and pulls power-good low.
// - after shutdown wait 512 cycles plus one soft-start interval.
// - counter cleared when entering the cooling delay.
// - delay expiry starts a normal soft-start automatically.
// - successful soft-start releases power-good and resumes regulation.
// - restart shuts down again only on a fresh overflow; repeats forever.
// - frequency pin low gives 500 kHz, high gives 300 kHz.
// - when synchronised, cycles start in phase with the sync clock.
// - internal oscillator until power-good; sync used only afterwards.
// - select 00 all ten blocks, 01 blocks 5-8, 10 blocks 5-6, 11 none.
// - select 11 is sleep with every phase output high impedance.
// - leaving sleep ramps over one soft-start, skipping pre-initialization.
// - trip level scaled by the number of active blocks.
// - two independent trip channels guard against single-event upsets.
// - wait 32 cycles after enable and supply threshold before soft-start.
// - enable or supply loss discharges soft-start for 256 cycles.
// - power-good goes low as soon as enable drops.
module bfcc_core (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       enable_i,
  input  wire logic       por_ok_i,
  input  wire logic       freq_choice_pin_i,
  input  wire logic       block_count_bit0_i,
  input  wire logic       block_count_bit1_i,
  input  wire logic       sync_clk_i,
  input  wire logic       current_limit_trip_a_i,
  input  wire logic       current_limit_trip_b_i,
  input  wire logic       ss_done_i,
  input  wire logic       pwm_end_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic [31:0]     reg_rdata_o,
  output logic            hs_gate_o,
  output logic            cycle_start_o,
  output logic [9:0]      phase_node_outputs_o,
  output logic            phase_node_hiz_o,
  output logic [3:0]      trip_scale_o,
  output logic            ss_discharge_o,
  output logic            sync_active_o,
  output logic            supply_ok_flag_o,
  output logic            supply_ok_flag_oe_n_o
);

  function automatic logic [9:0] blk_mask(input logic [1:0] sel);
    case (sel)
      bfcc_pkg::SEL_ALL:  blk_mask = bfcc_pkg::BLK_ALL;
      bfcc_pkg::SEL_FOUR: blk_mask = bfcc_pkg::BLK_FOUR;
      bfcc_pkg::SEL_TWO:  blk_mask = bfcc_pkg::BLK_TWO;
      default:            blk_mask = bfcc_pkg::BLK_NONE;
    endcase
  endfunction

  function automatic logic [3:0] blk_count(input logic [1:0] sel);
    case (sel)
      bfcc_pkg::SEL_ALL:  blk_count = bfcc_pkg::CNT_ALL;
      bfcc_pkg::SEL_FOUR: blk_count = bfcc_pkg::CNT_FOUR;
      bfcc_pkg::SEL_TWO:  blk_count = bfcc_pkg::CNT_TWO;
      default:            blk_count = bfcc_pkg::CNT_NONE;
    endcase
  endfunction

  bfcc_pkg::bfcc_pins_t  pins_raw;
  bfcc_pkg::bfcc_pins_t  meta_q;
  bfcc_pkg::bfcc_pins_t  pin_q;
  logic                  sync_prev_q;
  bfcc_pkg::bfcc_state_t state_q;
  bfcc_pkg::bfcc_state_t state_d;
  logic [9:0]            tmr_q;
  logic [7:0]            div_q;
  logic [7:0]            period;
  logic [7:0]            limit;
  logic [1:0]            miss_q;
  logic                  sync_act_q;
  logic                  cyc_pulse;
  logic                  sync_rise;
  logic                  en_ok;
  logic                  sleep_req;
  logic                  sw;
  logic                  trip_now;
  logic                  oc_seen_q;
  logic                  oc_hit;
  logic                  oc_ovf;
  logic [2:0]            oc_cnt_q;
  logic                  hs_q;
  logic                  cyc_q;
  logic [9:0]            blk_q;
  logic                  hiz_q;
  logic [3:0]            scale_q;
  logic                  ssd_q;
  logic                  pg_oe_n_q;
  logic [1:0]            ctrl_q;
  logic [7:0]            faults_q;
  logic [31:0]           rdata_q;
  bfcc_pkg::bfcc_status_t status;

  assign pins_raw = '{enable: enable_i, por_ok: por_ok_i, freq_choice: freq_choice_pin_i,
                      block_sel: {block_count_bit1_i, block_count_bit0_i},
                      sync_clk: sync_clk_i, trip_a: current_limit_trip_a_i,
                      trip_b: current_limit_trip_b_i, ss_done: ss_done_i};

  // two-stage synchroniser, meta_q is read only by pin_q
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q      <= '0;
      pin_q       <= '0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      meta_q      <= pins_raw;
      pin_q       <= meta_q;
      sync_prev_q <= pin_q.sync_clk;
    end
  end

  assign en_ok     = pin_q.enable && pin_q.por_ok;
  assign sleep_req = (pin_q.block_sel == bfcc_pkg::SEL_SLEEP);
  assign sync_rise = pin_q.sync_clk && !sync_prev_q;
  assign sw        = (state_q == bfcc_pkg::ST_SOFTSTART) || (state_q == bfcc_pkg::ST_RUN);

  assign period = pin_q.freq_choice ? bfcc_pkg::PER_SLOW : bfcc_pkg::PER_FAST;
  // a slow sync edge may trail the internal period by up to 25 percent, so stretch the guard
  assign limit  = sync_act_q ? 8'(period + (period >> 2)) : period;
  // sync edge starts the cycle in phase
  assign cyc_pulse = (sync_act_q && sync_rise) || (div_q >= 8'(limit - 8'h01));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_q <= '0;
    else if (cyc_pulse)
      div_q <= '0;
    else
      div_q <= 8'(div_q + 8'h01);
  end

  // sync only once in regulation with power-good released; a lost sync
  // clock falls back to the internal oscillator after a few missed edges
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      miss_q     <= '0;
      sync_act_q <= 1'b0;
    end
    else
    begin
      if (sync_rise)
        miss_q <= '0;
      else if (cyc_pulse && miss_q != bfcc_pkg::SYNC_MISS_MAX)
        miss_q <= 2'(miss_q + 2'h1);
      sync_act_q <= (state_d == bfcc_pkg::ST_RUN) && ctrl_q[bfcc_pkg::CTRL_SYNC_EN]
                    && (miss_q != bfcc_pkg::SYNC_MISS_MAX);
    end
  end

  // two channels; voting mode asks both to agree
  assign trip_now = ctrl_q[bfcc_pkg::CTRL_VOTE] ? (pin_q.trip_a && pin_q.trip_b)
                                                : (pin_q.trip_a || pin_q.trip_b);
  // one verdict per switching cycle, taken at the cycle boundary
  assign oc_hit = oc_seen_q || (trip_now && hs_q);
  assign oc_ovf = cyc_pulse && sw && oc_hit && (oc_cnt_q == 3'(bfcc_pkg::OC_OVERFLOW - 3'h1));

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      oc_seen_q <= 1'b0;
    else if (cyc_pulse || !sw)
      oc_seen_q <= 1'b0;
    else if (trip_now && hs_q)
      oc_seen_q <= 1'b1;
  end

  // high side off on trip, back on only at the next cycle start
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      hs_q <= 1'b0;
    else if (state_d != bfcc_pkg::ST_SOFTSTART && state_d != bfcc_pkg::ST_RUN)
      hs_q <= 1'b0;
    else if (cyc_pulse)
      hs_q <= 1'b1;
    else if (trip_now || pwm_end_i)
      hs_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      oc_cnt_q <= '0;
    else if (state_d == bfcc_pkg::ST_COOL || !sw)
      oc_cnt_q <= '0;
    else if (cyc_pulse)
    begin
      if (oc_hit && oc_cnt_q == 3'h0)
        oc_cnt_q <= bfcc_pkg::OC_FIRST;
      else if (oc_hit)
        oc_cnt_q <= 3'(oc_cnt_q + 3'h1);
      else
        oc_cnt_q <= '0;
    end
  end

  // sequencer; every count advances on the active switching cycle
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bfcc_pkg::ST_OFF:
        if (en_ok)
          state_d = bfcc_pkg::ST_WAIT;
      bfcc_pkg::ST_DISCHARGE:
        if (cyc_pulse && tmr_q == 10'(bfcc_pkg::DISCHARGE_CYC - 10'h001))
          state_d = bfcc_pkg::ST_OFF;
      bfcc_pkg::ST_WAIT:
        if (cyc_pulse && tmr_q == 10'(bfcc_pkg::START_WAIT_CYC - 10'h001))
          state_d = bfcc_pkg::ST_SOFTSTART;
      bfcc_pkg::ST_SOFTSTART:
        // during restart only an overflow shuts down again
        if (oc_ovf)
          state_d = bfcc_pkg::ST_COOL;
        else if (sleep_req)
          state_d = bfcc_pkg::ST_SLEEP;
        else if (pin_q.ss_done)
          state_d = bfcc_pkg::ST_RUN;
      bfcc_pkg::ST_RUN:
        if (oc_ovf)
          state_d = bfcc_pkg::ST_COOL;
        else if (sleep_req)
          state_d = bfcc_pkg::ST_SLEEP;
      bfcc_pkg::ST_SLEEP:
        if (!sleep_req)
          state_d = bfcc_pkg::ST_SOFTSTART;
      // 512 cycles, then one soft-start interval with switching held off
      bfcc_pkg::ST_COOL:
        if (cyc_pulse && tmr_q == 10'(bfcc_pkg::COOL_CYC - 10'h001))
          state_d = bfcc_pkg::ST_COOL_SS;
      // delay over, restart through the normal sequence
      bfcc_pkg::ST_COOL_SS:
        if (pin_q.ss_done)
          state_d = bfcc_pkg::ST_DISCHARGE;
      default:
        state_d = bfcc_pkg::ST_DISCHARGE;
    endcase
    // enable or supply loss overrides every state except off and discharge
    if (!en_ok && state_q != bfcc_pkg::ST_OFF && state_q != bfcc_pkg::ST_DISCHARGE)
      state_d = bfcc_pkg::ST_DISCHARGE;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_q <= bfcc_pkg::ST_OFF;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tmr_q <= '0;
    else if (state_d != state_q)
      tmr_q <= '0;
    else if (cyc_pulse)
      tmr_q <= 10'(tmr_q + 10'h001);
  end

  // output stage, all registered; blocks, discharge and power-good decoded from the next state
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cyc_q     <= 1'b0;
      blk_q     <= bfcc_pkg::BLK_NONE;
      hiz_q     <= 1'b1;
      scale_q   <= bfcc_pkg::CNT_NONE;
      ssd_q     <= 1'b1;
      pg_oe_n_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_pulse;
      // decode active blocks; sleep or idle leaves all outputs floating
      if (state_d == bfcc_pkg::ST_SOFTSTART || state_d == bfcc_pkg::ST_RUN)
      begin
        blk_q <= blk_mask(pin_q.block_sel);
        hiz_q <= (blk_mask(pin_q.block_sel) == bfcc_pkg::BLK_NONE);
      end
      else
      begin
        blk_q <= bfcc_pkg::BLK_NONE;
        hiz_q <= 1'b1;
      end
      // trip reference follows active block count
      scale_q <= blk_count(pin_q.block_sel);
      ssd_q   <= (state_d != bfcc_pkg::ST_SOFTSTART) && (state_d != bfcc_pkg::ST_RUN)
                 && (state_d != bfcc_pkg::ST_COOL_SS);
      // pull low at once, released only while regulating
      pg_oe_n_q <= (state_d == bfcc_pkg::ST_RUN) && en_ok;
    end
  end

  // register port; a shutdown in the same cycle as a clear still counts
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_q   <= bfcc_pkg::CTRL_RESET;
      faults_q <= '0;
    end
    else
    begin
      if (reg_we_i && reg_addr_i == bfcc_pkg::ADDR_CTRL)
        ctrl_q <= reg_wdata_i[1:0];
      if (oc_ovf)
        faults_q <= (faults_q == 8'hFF) ? faults_q : 8'(faults_q + 8'h01);
      else if (reg_we_i && reg_addr_i == bfcc_pkg::ADDR_FAULTS)
        faults_q <= '0;
    end
  end

  assign status = '{switching: sw, pg_released: pg_oe_n_q, sync_active: sync_act_q,
                    oc_count: oc_cnt_q, state: state_q};

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_q <= '0;
    else if (reg_re_i)
    begin
      case (reg_addr_i)
        bfcc_pkg::ADDR_CTRL:   rdata_q <= {30'h0, ctrl_q};
        bfcc_pkg::ADDR_STATUS: rdata_q <= {22'h0, status};
        bfcc_pkg::ADDR_FAULTS: rdata_q <= {24'h0, faults_q};
        default:               rdata_q <= '0;
      endcase
    end
    else
      rdata_q <= '0;
  end

  assign reg_rdata_o           = rdata_q;
  assign hs_gate_o             = hs_q;
  assign cycle_start_o         = cyc_q;
  assign phase_node_outputs_o  = blk_q;
  assign phase_node_hiz_o      = hiz_q;
  assign trip_scale_o          = scale_q;
  assign ss_discharge_o        = ssd_q;
  assign sync_active_o         = sync_act_q;
  assign supply_ok_flag_o      = 1'b0;
  assign supply_ok_flag_oe_n_o = pg_oe_n_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_HS_OFF: assert property (
    trip_now && hs_q && !cyc_pulse && sw |=> !hs_q)
    else $error("high side stayed on after trip");
  AST_FIRST_ONE: assert property (
    cyc_pulse && sw && oc_hit && oc_cnt_q == 3'h0 && state_d != bfcc_pkg::ST_COOL
    |=> oc_cnt_q == bfcc_pkg::OC_FIRST)
    else $error("first trip did not load one");
  AST_INC: assert property (
    cyc_pulse && sw && oc_hit && oc_cnt_q != 3'h0 && en_ok && !oc_ovf
    |=> oc_cnt_q == 3'($past(oc_cnt_q) + 3'h1))
    else $error("counter did not increment");
  AST_CLEAN: assert property (
    cyc_pulse && sw && !oc_hit |=> oc_cnt_q == 3'h0)
    else $error("clean cycle kept the count");
  AST_OVF: assert property (
    oc_ovf && en_ok |=> state_q == bfcc_pkg::ST_COOL && !pg_oe_n_q && hiz_q)
    else $error("overflow did not shut down");
  AST_COOL_END: assert property (
    state_q == bfcc_pkg::ST_COOL && en_ok && cyc_pulse
    && tmr_q == 10'(bfcc_pkg::COOL_CYC - 10'h001) |=> state_q == bfcc_pkg::ST_COOL_SS)
    else $error("cooling delay length wrong");
  AST_COOL_CLR: assert property (
    state_q == bfcc_pkg::ST_COOL |-> oc_cnt_q == 3'h0)
    else $error("counter not clear in cooling");
  AST_WAIT: assert property (
    state_q == bfcc_pkg::ST_WAIT && en_ok && cyc_pulse
    && tmr_q == 10'(bfcc_pkg::START_WAIT_CYC - 10'h001) |=> state_q == bfcc_pkg::ST_SOFTSTART)
    else $error("start wait length wrong");
  AST_PG_EN: assert property (
    !pin_q.enable |=> !pg_oe_n_q [*2])
    else $error("power-good released with enable low");
  AST_SYNC_RUN: assert property (
    sync_act_q |-> state_q == bfcc_pkg::ST_RUN && pg_oe_n_q)
    else $error("sync used outside regulation");
  AST_SLEEP: assert property (
    sleep_req && state_q == bfcc_pkg::ST_RUN && en_ok && !oc_ovf
    |=> hiz_q && blk_q == bfcc_pkg::BLK_NONE)
    else $error("sleep left outputs driven");
  AST_LOSS: assert property (
    $fell(en_ok) && state_q != bfcc_pkg::ST_OFF |=> state_q == bfcc_pkg::ST_DISCHARGE && ssd_q)
    else $error("supply loss did not discharge");

  COV_HICCUP: cover property (state_q == bfcc_pkg::ST_COOL_SS ##1 state_q == bfcc_pkg::ST_DISCHARGE);
  COV_WAKE:   cover property (state_q == bfcc_pkg::ST_SLEEP ##1 state_q == bfcc_pkg::ST_SOFTSTART);
  COV_SYNC:   cover property ($rose(sync_act_q));
  COV_RUN:    cover property ($rose(pg_oe_n_q));

endmodule // bfcc_core

`default_nettype wire

// ---- rtl/bfcc_pkg.sv ----
// constants, state codes and carrier types for the buck fault and config control
// assumes a 40 MHz system clock and comparators that flag trips as levels
package bfcc_pkg;

  // timing base
  localparam int unsigned CLK_KHZ      = 40000;
  localparam int unsigned FSW_FAST_KHZ = 500;
  localparam int unsigned FSW_SLOW_KHZ = 300;
  localparam logic [7:0]  PER_FAST     = 8'(CLK_KHZ / FSW_FAST_KHZ);
  localparam logic [7:0]  PER_SLOW     = 8'(CLK_KHZ / FSW_SLOW_KHZ);

  // sequence lengths in switching cycles
  localparam logic [9:0]  START_WAIT_CYC = 10'h020;
  localparam logic [9:0]  DISCHARGE_CYC  = 10'h100;
  localparam logic [9:0]  COOL_CYC       = 10'h200;
  localparam logic [1:0]  SYNC_MISS_MAX  = 2'h2;

  // overcurrent counter
  localparam logic [2:0]  OC_FIRST    = 3'h1;
  localparam logic [2:0]  OC_OVERFLOW = 3'h4;

  // block select codes and enable masks, bit n is power block n+1
  localparam logic [1:0]  SEL_ALL   = 2'h0;
  localparam logic [1:0]  SEL_FOUR  = 2'h1;
  localparam logic [1:0]  SEL_TWO   = 2'h2;
  localparam logic [1:0]  SEL_SLEEP = 2'h3;
  localparam logic [9:0]  BLK_ALL   = 10'h3FF;
  localparam logic [9:0]  BLK_FOUR  = 10'h0F0;
  localparam logic [9:0]  BLK_TWO   = 10'h030;
  localparam logic [9:0]  BLK_NONE  = 10'h000;
  localparam logic [3:0]  CNT_ALL   = 4'hA;
  localparam logic [3:0]  CNT_FOUR  = 4'h4;
  localparam logic [3:0]  CNT_TWO   = 4'h2;
  localparam logic [3:0]  CNT_NONE  = 4'h0;

  // register port
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_FAULTS = 4'h8;
  localparam int unsigned CTRL_SYNC_EN = 0;
  localparam int unsigned CTRL_VOTE    = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h3;

  typedef enum logic [3:0] {
    ST_OFF,
    ST_DISCHARGE,
    ST_WAIT,
    ST_SOFTSTART,
    ST_RUN,
    ST_SLEEP,
    ST_COOL,
    ST_COOL_SS
  } bfcc_state_t;

  typedef struct packed {
    logic        switching;
    logic        pg_released;
    logic        sync_active;
    logic [2:0]  oc_count;
    bfcc_state_t state;
  } bfcc_status_t;

  // asynchronous pins, passed through the synchroniser as one bundle
  typedef struct packed {
    logic       enable;
    logic       por_ok;
    logic       freq_choice;
    logic [1:0] block_sel;
    logic       sync_clk;
    logic       trip_a;
    logic       trip_b;
    logic       ss_done;
  } bfcc_pins_t;

endpackage

// ---- test/bfcc_core_bench.sv ----
// bench for bfcc_core: start-up, sync hand-over, select decode, overcurrent hiccup
// assumes bfcc_far_model stands in for the soft-start node and modulator
`timescale 1ns/100ps
`default_nettype none
module bfcc_core_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b0, por = 1'b0, freq_choice_pin = 1'b0, sync = 1'b0, sync_on = 1'b0;
  logic        ta = 1'b0, tb = 1'b0, slow = 1'b0, we = 1'b0, re = 1'b0, re_q = 1'b0;
  logic [1:0]  bsel = 2'h0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rv, e, m;
  logic        hs, cs, hiz, ssd, sact, pgd, pgoe, ssdone, pwme, pgw;
  logic [9:0]  blk;
  logic [3:0]  scale;
  logic [63:0] expq [$];
  int          n_errors = 0, num_checks = 0, cyc = 0, sdiv = 0, seed = 82, n, t0;
  logic [1:0]  sel [3] = '{bfcc_pkg::SEL_FOUR, bfcc_pkg::SEL_TWO, bfcc_pkg::SEL_ALL};
  logic [9:0]  msk [3] = '{bfcc_pkg::BLK_FOUR, bfcc_pkg::BLK_TWO, bfcc_pkg::BLK_ALL};
  logic [3:0]  cnt [3] = '{bfcc_pkg::CNT_FOUR, bfcc_pkg::CNT_TWO, bfcc_pkg::CNT_ALL};

  bfcc_core u_bfcc_core (
    .clk_i(clk), .reset_n_i(rst_n), .enable_i(en), .por_ok_i(por),
    .freq_choice_pin_i(freq_choice_pin), .block_count_bit0_i(bsel[0]), .block_count_bit1_i(bsel[1]),
    .sync_clk_i(sync), .current_limit_trip_a_i(ta), .current_limit_trip_b_i(tb),
    .ss_done_i(ssdone), .pwm_end_i(pwme), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .hs_gate_o(hs),
    .cycle_start_o(cs), .phase_node_outputs_o(blk), .phase_node_hiz_o(hiz),
    .trip_scale_o(scale), .ss_discharge_o(ssd), .sync_active_o(sact),
    .supply_ok_flag_o(pgd), .supply_ok_flag_oe_n_o(pgoe)
  );
  bfcc_far_model u_bfcc_far_model (
    .clk_i(clk), .reset_n_i(rst_n), .ss_discharge_i(ssd), .cycle_start_i(cs),
    .pg_data_i(pgd), .pg_oe_n_i(pgoe), .slow_i(slow), .ss_done_o(ssdone),
    .pwm_end_o(pwme), .pg_wire_o(pgw)
  );

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic c, input string s);
    num_checks++;
    if (c !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask

  task automatic wc(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // the expectation is queued here and judged by the read monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] ev, input logic [31:0] mv);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    expq.push_back({ev, mv});
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    rv = rdata;
    // hand back on a rising edge so that later stimulus lands there too
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(negedge clk)
  begin
    if (re_q === 1'b1)
    begin
      {e, m} = expq.pop_front();
      chk((rdata & m) === (e & m), "read data");
    end
  end

  // sync at 84 clocks, inside the allowed band around 500 kHz
  always @(posedge clk)
  begin
    re_q <= re;
    cyc <= cyc + 1;
    sdiv <= (sdiv == 83) ? 0 : sdiv + 1;
    sync <= sync_on && sdiv < 42;
    // full hiccup (cool, discharge, wait) takes about 64k clocks
    if (cyc == 90000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(hiz === 1'b1 && ssd === 1'b1 && pgoe === 1'b0 && blk === 10'h000, "reset");
    rd(bfcc_pkg::ADDR_CTRL, 32'(bfcc_pkg::CTRL_RESET), '1);
    repeat (3)
    begin
      wr({2'h3, 2'($random(seed))}, $random(seed));
      rd({2'h3, 2'($random(seed))}, 32'h0, '1);
    end
    rd(bfcc_pkg::ADDR_CTRL, 32'(bfcc_pkg::CTRL_RESET), '1);
    en <= 1'b1;
    por <= 1'b1;
    wc(5);
    n = 0;
    while (ssd !== 1'b0)
    begin
      @(posedge clk);
      if (cs === 1'b1)
      begin
        n++;
        if (n == 2)
          t0 = cyc;
        if (n == 3)
          chk(cyc - t0 == int'(bfcc_pkg::PER_FAST), "fast period");
      end
    end
    chk(n >= 32 && n <= 33, "start wait");
    sync_on <= 1'b1;
    n = 0;
    while (pgoe !== 1'b1)
    begin
      @(posedge clk);
      // sync may engage on the very edge that releases power-good, not before
      if (sact === 1'b1 && pgoe !== 1'b1)
        n++;
    end
    chk(n == 0, "sync before release");
    chk(blk === bfcc_pkg::BLK_ALL && scale === bfcc_pkg::CNT_ALL, "all blocks");
    repeat (4) @(posedge clk iff cs === 1'b1);
    chk(sact === 1'b1, "sync taken");
    @(posedge sync);
    n = 0;
    repeat (8)
    begin
      @(posedge clk);
      if (cs === 1'b1)
        n++;
    end
    chk(n == 1, "cycle follows sync");
    sync_on <= 1'b0;
    repeat (4) @(posedge clk iff cs === 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      bsel <= bfcc_pkg::SEL_SLEEP;
      wc(8);
      chk(hiz === 1'b1 && ssd === 1'b1, "sleep");
      bsel <= sel[i];
      wc(8);
      chk(hiz === 1'b0 && ssd === 1'b0, "wake");
      chk(blk === msk[i] && scale === cnt[i], "block decode");
      while (pgoe !== 1'b1)
        @(posedge clk);
    end
    ta <= 1'b1;
    repeat (3) @(posedge clk iff cs === 1'b1);
    rd(bfcc_pkg::ADDR_STATUS, 32'(bfcc_pkg::ST_RUN), 32'h7F);
    ta <= 1'b0;
    @(posedge clk iff cs === 1'b1);
    wc(5);
    chk(hs === 1'b1, "gate on");
    ta <= 1'b1;
    tb <= 1'b1;
    wc(6);
    chk(hs === 1'b0, "gate cut");
    wc(30);
    chk(hs === 1'b0, "gate held off");
    for (int k = 1; k < 4; k++)
    begin
      @(posedge clk iff cs === 1'b1);
      wc(4);
      rd(bfcc_pkg::ADDR_STATUS, 32'({3'(k), 4'(bfcc_pkg::ST_RUN)}), 32'h7F);
    end
    @(posedge clk iff cs === 1'b1);
    wc(4);
    rd(bfcc_pkg::ADDR_STATUS, 32'(bfcc_pkg::ST_COOL), 32'h7F);
    chk(pgw === 1'b0 && hiz === 1'b1, "fault shutdown");
    rd(bfcc_pkg::ADDR_FAULTS, 32'h1, '1);
    wr(bfcc_pkg::ADDR_FAULTS, $random(seed));
    rd(bfcc_pkg::ADDR_FAULTS, 32'h0, '1);
    ta <= 1'b0;
    tb <= 1'b0;
    // last read was the fault count, so fetch the state before polling on it
    rd(bfcc_pkg::ADDR_STATUS, 32'(bfcc_pkg::ST_COOL), 32'h7F);
    n = 0;
    while (rv[3:0] === 4'(bfcc_pkg::ST_COOL))
    begin
      @(posedge clk iff cs === 1'b1);
      n++;
      rd(bfcc_pkg::ADDR_STATUS, 32'h0, 32'h0);
    end
    chk(n >= 511 && n <= 513, "cooling delay");
    slow <= 1'b1;
    while (rv[3:0] !== 4'(bfcc_pkg::ST_SOFTSTART))
      rd(bfcc_pkg::ADDR_STATUS, 32'h0, 32'h0);
    ta <= 1'b1;
    tb <= 1'b1;
    repeat (2) @(posedge clk iff cs === 1'b1);
    ta <= 1'b0;
    tb <= 1'b0;
    while (pgoe !== 1'b1)
      @(posedge clk);
    rd(bfcc_pkg::ADDR_STATUS, 32'(bfcc_pkg::ST_RUN), 32'h7F);
    en <= 1'b0;
    wc(5);
    chk(pgoe === 1'b0 && ssd === 1'b1, "disable");
    freq_choice_pin <= 1'b1;
    repeat (3) @(posedge clk iff cs === 1'b1);
    t0 = cyc;
    @(posedge clk iff cs === 1'b1);
    chk(cyc - t0 == int'(bfcc_pkg::PER_SLOW), "slow period");
    rd(bfcc_pkg::ADDR_STATUS, 32'(bfcc_pkg::ST_DISCHARGE), 32'hF);
    print_verdict();
  end
endmodule // bfcc_core_bench
`default_nettype wire

// ---- test/bfcc_far_model.sv ----
// analog side of the core: soft-start node, modulator pulse end, power-good pull-up
// assumes the core's clock and its active-low reset
`timescale 1ns/100ps
`default_nettype none
module bfcc_far_model #(
  parameter int SS_CLK = 300
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ss_discharge_i,
  input  wire logic cycle_start_i,
  input  wire logic pg_data_i,
  input  wire logic pg_oe_n_i,
  input  wire logic slow_i,
  output logic      ss_done_o,
  output logic      pwm_end_o,
  output wire logic pg_wire_o
);
  int ss_cnt;
  int pw_cnt;
  // the pull-up wins whenever the drain lets go
  assign pg_wire_o = pg_oe_n_i ? 1'b1 : pg_data_i;
  // node charges only while released; slow mode doubles the ramp
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ss_cnt <= 0;
      ss_done_o <= 1'b0;
      pw_cnt <= 0;
      pwm_end_o <= 1'b0;
    end
    else
    begin
      ss_cnt <= ss_discharge_i ? 0 : ss_cnt + 1;
      ss_done_o <= !ss_discharge_i && ss_cnt >= (slow_i ? 2 * SS_CLK : SS_CLK);
      pw_cnt <= cycle_start_i ? 1 : (pw_cnt == 0 ? 0 : pw_cnt + 1);
      pwm_end_o <= pw_cnt == 30;
    end
  end
endmodule // bfcc_far_model
`default_nettype wire
